// File: rtl/tmr_cfg.svh
// Offsets, reset values and timing counts of the waveform timer
`ifndef TMR_CFG_SVH
`define TMR_CFG_SVH
`define OFS_CTRL_ONE  8'h00
`define OFS_CTRL_TWO  8'h04
`define OFS_STATUS    8'h08
`define OFS_CAP1_HI   8'h0C
`define OFS_CAP1_LO   8'h10
`define OFS_CMP1_HI   8'h14
`define OFS_CMP1_LO   8'h18
`define OFS_CMP2_HI   8'h1C
`define OFS_CMP2_LO   8'h20
`define OFS_CNT_HI    8'h24
`define OFS_CNT_LO    8'h28
`define OFS_CAP2_HI   8'h2C
`define OFS_CAP2_LO   8'h30
`define CNT_RESTART   16'hFFFC
`define CAP1_TRIG_VAL 16'hFFFD
`define CNT_TOP       16'hFFFF
`define CMP_RESET     16'h8000
`define CAP_RESET     16'h0000
`define CTRL_RESET    8'h00
`define DIV2_MASK     3'h1
`define DIV4_MASK     3'h3
`define DIV8_MASK     3'h7
`endif

// File: rtl/tmr_pkg.sv
// Types shared by the waveform timer
package tmr_pkg;
    typedef struct packed {
        logic cap_irq_en;
        logic cmp_irq_en;
        logic ovf_irq_en;
        logic force_output_bit2;
        logic force_output_bit1;
        logic second_output_level;
        logic trigger_edge_select;
        logic first_output_level;
    } ctrl_one_s;
    typedef struct packed {
        logic       compare_pin_enable1;
        logic       compare_pin_enable2;
        logic       one_pulse_select;
        logic       pwm_select;
        logic [1:0] clock_select_field;
        logic       capture2_edge_select;
        logic       ext_edge_select;
    } ctrl_two_s;
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_ONE_PULSE,
        MODE_PWM
    } mode_e;
endpackage : tmr_pkg

// File: rtl/wave_timer.sv
// 16-bit timer with forced compare, one pulse and PWM modes
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "tmr_cfg.svh"
module wave_timer (
    input  wire logic                sys_clk,
    input  wire logic                rstn,
    input  wire logic                wb_cyc_i,
    input  wire logic                wb_stb_i,
    input  wire logic                wb_we_i,
    input  wire logic [7:0]          wb_adr_i,
    input  wire logic [3:0]          wb_sel_i,
    input  wire logic [31:0]         wb_dat_i,
    output logic [31:0]              wb_dat_o,
    output logic                     wb_ack_o,
    input  wire logic                capture_pin_1,
    input  wire logic                capture_pin_2,
    input  wire logic                ext_clk_pin,
    input  wire logic                halt_mode,
    output logic                     compare_output_pin_1,
    output logic                     compare_output_oe_1,
    output logic                     compare_output_pin_2,
    output logic                     compare_output_oe_2,
    output logic                     timer_irq,
    output tmr_pkg::mode_e           mode
);
    import tmr_pkg::*;

    ////////////////////////////////////////////////////////////////////
    ctrl_one_s   c1_q;
    ctrl_two_s   c2_q;
    logic [15:0] cnt_q;
    logic [15:0] cmp_q [2];
    logic [15:0] cap_q [2];
    logic [1:0]  inh_q;
    logic [4:0]  flag_q;
    logic [4:0]  arm_q;
    logic [4:0]  flag_set;
    logic [4:0]  low_acc;
    logic [1:0]  pend_q;
    logic [2:0]  div_q;
    logic [2:0]  s1_q;
    logic [2:0]  s2_q;
    logic [2:0]  s3_q;
    logic        halt_q;
    logic        out1_q;
    logic        out2_q;
    logic        ack_q;
    logic [31:0] rd_q;
    logic        acc;
    logic        wr;
    logic        rd_sr;
    logic        tick;
    logic        tick_run;
    logic [2:0]  edge_hit;
    logic        cap1_edge;
    logic        cap2_edge;
    logic        ext_edge;
    logic        trig;
    logic        halt_exit;
    logic [1:0]  match;
    logic        normal;
    logic [7:0]  status;

    ////////////////////////////////////////////////////////////////////
    // Mode decode; PWM beats one pulse when both are set
    always_comb begin
        if (c2_q.pwm_select)
            mode = MODE_PWM;
        else if (c2_q.one_pulse_select)
            mode = MODE_ONE_PULSE;
        else
            mode = MODE_NORMAL;
    end
    assign normal = (mode == MODE_NORMAL);

    ////////////////////////////////////////////////////////////////////
    // Wishbone slave: one wait state, ack drops the cycle after
    assign acc   = wb_cyc_i & wb_stb_i & ack_q;
    assign wr    = acc & wb_we_i & wb_sel_i[0];
    assign rd_sr = acc & ~wb_we_i & (wb_adr_i == `OFS_STATUS);
    assign status = {flag_q[0], flag_q[1], flag_q[2], flag_q[3],
                     flag_q[4], 3'h0};
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rd_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            ack_q <= 1'b0;
        else
            ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
    end

    // Read data is latched while the request waits for ack
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rd_q <= 32'h0;
        end else begin
            unique case (wb_adr_i)
                `OFS_CTRL_ONE: rd_q <= {24'h0, c1_q};
                `OFS_CTRL_TWO: rd_q <= {24'h0, c2_q};
                `OFS_STATUS:   rd_q <= {24'h0, status};
                `OFS_CAP1_HI:  rd_q <= {24'h0, cap_q[0][15:8]};
                `OFS_CAP1_LO:  rd_q <= {24'h0, cap_q[0][7:0]};
                `OFS_CMP1_HI:  rd_q <= {24'h0, cmp_q[0][15:8]};
                `OFS_CMP1_LO:  rd_q <= {24'h0, cmp_q[0][7:0]};
                `OFS_CMP2_HI:  rd_q <= {24'h0, cmp_q[1][15:8]};
                `OFS_CMP2_LO:  rd_q <= {24'h0, cmp_q[1][7:0]};
                `OFS_CNT_HI:   rd_q <= {24'h0, cnt_q[15:8]};
                `OFS_CNT_LO:   rd_q <= {24'h0, cnt_q[7:0]};
                `OFS_CAP2_HI:  rd_q <= {24'h0, cap_q[1][15:8]};
                `OFS_CAP2_LO:  rd_q <= {24'h0, cap_q[1][7:0]};
                default:       rd_q <= 32'h0;
            endcase
        end
    end

    // Control registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            c1_q <= `CTRL_RESET;
            c2_q <= `CTRL_RESET;
        end else if (wr) begin
            if (wb_adr_i == `OFS_CTRL_ONE)
                c1_q <= wb_dat_i[7:0];
            if (wb_adr_i == `OFS_CTRL_TWO)
                c2_q <= wb_dat_i[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers; stage one feeds only stage two
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            s1_q   <= 3'h0;
            s2_q   <= 3'h0;
            s3_q   <= 3'h0;
            halt_q <= 1'b0;
        end else begin
            s1_q   <= {ext_clk_pin, capture_pin_2, capture_pin_1};
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            halt_q <= halt_mode;
        end
    end

    // Edge polarity per pin: select 1 means rising
    assign edge_hit = (s2_q ^ s3_q) &
                      ~(s2_q ^ {c2_q.ext_edge_select,
                                c2_q.capture2_edge_select,
                                c1_q.trigger_edge_select});
    assign cap1_edge = edge_hit[0];
    assign cap2_edge = edge_hit[1];
    assign ext_edge  = edge_hit[2];
    assign halt_exit = halt_q & ~halt_mode;

    ////////////////////////////////////////////////////////////////////
    // Prescaler; free running so a select change takes effect at once
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            div_q <= 3'h0;
        else
            div_q <= div_q + 3'h1;
    end

    always_comb begin
        unique case (c2_q.clock_select_field)
            2'h0: tick = (div_q[1:0] == `DIV4_MASK);
            2'h1: tick = (div_q[0] == 1'b1);
            2'h2: tick = (div_q == `DIV8_MASK);
            2'h3: tick = ext_edge;
        endcase
    end
    // Halt stops counting; wait has no input here, so it never does
    assign tick_run = tick & ~halt_mode;

    // Compare matches, held off between high and low byte writes
    assign match[0] = tick_run & ~inh_q[0] & (cnt_q == cmp_q[0]);
    assign match[1] = tick_run & ~inh_q[1] & (cnt_q == cmp_q[1]);
    // Trigger only in one pulse mode; pin 1 is cut off in PWM
    assign trig = (mode == MODE_ONE_PULSE) & cap1_edge & ~halt_mode;

    ////////////////////////////////////////////////////////////////////
    // Free running counter with the mode restarts
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            cnt_q <= `CNT_RESTART;
        else if (trig)
            cnt_q <= `CNT_RESTART;
        else if (mode == MODE_PWM && match[1])
            cnt_q <= `CNT_RESTART;
        else if (tick_run)
            cnt_q <= cnt_q + 16'h1;
    end

    ////////////////////////////////////////////////////////////////////
    // Per channel: compare registers and high byte inhibit
    for (genvar k = 0; k < 2; k++) begin : g_cmp
        logic [7:0] hi_ofs;
        logic [7:0] lo_ofs;
        assign hi_ofs = k ? `OFS_CMP2_HI : `OFS_CMP1_HI;
        assign lo_ofs = k ? `OFS_CMP2_LO : `OFS_CMP1_LO;
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                cmp_q[k] <= `CMP_RESET;
                inh_q[k] <= 1'b0;
            end else if (wr && wb_adr_i == hi_ofs) begin
                cmp_q[k][15:8] <= wb_dat_i[7:0];
                inh_q[k]       <= 1'b1;
            end else if (wr && wb_adr_i == lo_ofs) begin
                cmp_q[k][7:0]  <= wb_dat_i[7:0];
                inh_q[k]       <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Halt arms capture; flag and count land at halt exit
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            pend_q <= 2'h0;
        else if (halt_exit)
            pend_q <= 2'h0;
        else if (halt_mode)
            pend_q <= pend_q | {cap2_edge, cap1_edge & normal};
    end

    // Capture registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cap_q[0] <= `CAP_RESET;
            cap_q[1] <= `CAP_RESET;
        end else begin
            if (trig)
                cap_q[0] <= `CAP1_TRIG_VAL;
            else if (normal && cap1_edge && !halt_mode)
                cap_q[0] <= cnt_q;
            else if (halt_exit && pend_q[0])
                cap_q[0] <= cnt_q;
            if ((cap2_edge && !halt_mode) || (halt_exit && pend_q[1]))
                cap_q[1] <= cnt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Flag sources: 0 cap1, 1 cmp1, 2 overflow, 3 cap2, 4 cmp2
    always_comb begin
        flag_set[0] = trig
                    | (mode == MODE_PWM && match[1])
                    | (normal && cap1_edge && !halt_mode)
                    | (halt_exit && pend_q[0]);
        flag_set[1] = normal & match[0];
        flag_set[2] = tick_run & (cnt_q == `CNT_TOP);
        flag_set[3] = (cap2_edge & ~halt_mode) | (halt_exit & pend_q[1]);
        flag_set[4] = (mode != MODE_PWM) & match[1];
    end

    // Low byte accesses that finish a flag clear
    always_comb begin
        low_acc[0] = acc & (wb_adr_i == `OFS_CAP1_LO);
        low_acc[1] = acc & (wb_adr_i == `OFS_CMP1_LO);
        low_acc[2] = acc & (wb_adr_i == `OFS_CNT_LO);
        low_acc[3] = acc & (wb_adr_i == `OFS_CAP2_LO);
        low_acc[4] = acc & (wb_adr_i == `OFS_CMP2_LO);
    end

    // Two step clear per flag; a new event beats the clear
    for (genvar f = 0; f < 5; f++) begin : g_flag
        always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
                flag_q[f] <= 1'b0;
                arm_q[f]  <= 1'b0;
            end else begin
                if (flag_set[f])
                    flag_q[f] <= 1'b1;
                else if (low_acc[f] && arm_q[f])
                    flag_q[f] <= 1'b0;
                if (rd_sr && flag_q[f])
                    arm_q[f] <= 1'b1;
                else if (low_acc[f])
                    arm_q[f] <= 1'b0;
            end
        end
    end

    // One timer interrupt; it also serves as the wake request
    assign timer_irq = (c1_q.cap_irq_en & (flag_q[0] | flag_q[3]))
                     | (c1_q.cmp_irq_en & (flag_q[1] | flag_q[4]))
                     | (c1_q.ovf_irq_en & flag_q[2]);

    ////////////////////////////////////////////////////////////////////
    // Output pin 1; equal levels set the pin once and never return it
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            out1_q <= 1'b0;
        end else begin
            unique case (mode)
                MODE_NORMAL: begin
                    if (c1_q.force_output_bit1)
                        out1_q <= c1_q.first_output_level;
                    else if (match[0])
                        out1_q <= c1_q.first_output_level;
                end
                MODE_ONE_PULSE: begin
                    if (trig)
                        out1_q <= c1_q.second_output_level;
                    else if (match[0])
                        out1_q <= c1_q.first_output_level;
                end
                MODE_PWM: begin
                    if (match[1])
                        out1_q <= c1_q.second_output_level;
                    else if (match[0])
                        out1_q <= c1_q.first_output_level;
                end
                default: out1_q <= out1_q;
            endcase
        end
    end

    // Output pin 2 is a plain compare output only in normal mode
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            out2_q <= 1'b0;
        else if (normal && (c1_q.force_output_bit2 || match[1]))
            out2_q <= c1_q.second_output_level;
    end

    assign compare_output_pin_1 = out1_q;
    assign compare_output_oe_1  = c2_q.compare_pin_enable1;
    assign compare_output_pin_2 = out2_q;
    assign compare_output_oe_2  = c2_q.compare_pin_enable2;

    ////////////////////////////////////////////////////////////////////
    // Checks
    a_force_level: assert property (@(posedge sys_clk) disable iff (!rstn)
        normal && c1_q.force_output_bit1 |=> out1_q == $past(c1_q.first_output_level))
        else $error("forced level not on pin 1");
    a_flag1_cause: assert property (@(posedge sys_clk) disable iff (!rstn)
        $rose(flag_q[1]) |-> $past(normal && match[0]))
        else $error("compare flag 1 set without normal match");
    a_trig_load: assert property (@(posedge sys_clk) disable iff (!rstn)
        trig |=> cnt_q == `CNT_RESTART && cap_q[0] == `CAP1_TRIG_VAL && flag_q[0]
                 && out1_q == $past(c1_q.second_output_level))
        else $error("one pulse trigger effects missing");
    a_pulse_end: assert property (@(posedge sys_clk) disable iff (!rstn)
        mode == MODE_ONE_PULSE && match[0] && !trig
        |=> out1_q == $past(c1_q.first_output_level))
        else $error("pulse did not end on compare 1");
    a_pwm_reload: assert property (@(posedge sys_clk) disable iff (!rstn)
        mode == MODE_PWM && match[1] |=> cnt_q == `CNT_RESTART && flag_q[0])
        else $error("PWM period restart missing");
    a_pwm_noflag: assert property (@(posedge sys_clk) disable iff (!rstn)
        mode == MODE_PWM && !flag_q[4] ##1 mode == MODE_PWM |-> !flag_q[4])
        else $error("compare flag 2 set in PWM");
    a_halt_freeze: assert property (@(posedge sys_clk) disable iff (!rstn)
        halt_mode ##1 halt_mode |-> $stable(cnt_q))
        else $error("counter moved during halt");
    a_cmp_inhibit: assert property (@(posedge sys_clk) disable iff (!rstn)
        wr && wb_adr_i == `OFS_CMP1_HI |=> !match[0])
        else $error("compare 1 matched after high write");
    a_clear_steps: assert property (@(posedge sys_clk) disable iff (!rstn)
        $fell(flag_q[0]) |-> $past(arm_q[0] && low_acc[0]))
        else $error("capture flag 1 cleared out of order");
    a_div4_tick: assert property (@(posedge sys_clk) disable iff (!rstn)
        c2_q.clock_select_field == 2'h0 && tick
        |-> div_q[1:0] == 2'h3 ##1 (!tick || c2_q.clock_select_field != 2'h0) [*3])
        else $error("divide by 4 tick spacing wrong");
endmodule : wave_timer
`default_nettype wire

// File: bench/pin_partner.sv
// Model of the trigger source and the pulled-down load on the compare pin
`timescale 1ns/1ns
`default_nettype none
module pin_partner (
    input  wire logic sys_clk,
    input  wire logic out_pin,
    input  wire logic out_oe,
    output logic      capture_pin_1,
    output logic      capture_pin_2,
    output logic      ext_clk_pin,
    output logic      pin_level
);
    logic [2:0] pins_q = 3'h0;

    // Released pin falls to the load's pull-down, not to a stale level
    assign pin_level = out_oe ? out_pin : 1'b0;

    // Source lines idle low between events
    assign capture_pin_1 = pins_q[0];
    assign capture_pin_2 = pins_q[1];
    assign ext_clk_pin   = pins_q[2];

    // One rise and one fall; each level held 6 clocks so the sync flops see it
    task automatic pulse(input int unsigned sel);
        @(posedge sys_clk);
        pins_q[sel] <= 1'b1;
        repeat (6) @(posedge sys_clk);
        pins_q[sel] <= 1'b0;
        repeat (6) @(posedge sys_clk);
    endtask : pulse
endmodule : pin_partner
`default_nettype wire

// File: bench/tb_timer_one_pulse_pwm_modes.sv
// Self-checking bench for the forced, one pulse and PWM timer modes
`timescale 1ns/1ns
`default_nettype none
`include "tmr_cfg.svh"
module tb_timer_one_pulse_pwm_modes;
    import tmr_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rstn    = 1'b0;
    logic        cyc     = 1'b0;
    logic        stb     = 1'b0;
    logic        we      = 1'b0;
    logic [7:0]  adr     = 8'h00;
    logic [31:0] dat_i   = 32'h0;
    logic [31:0] dat_o;
    logic        ack;
    logic        halt    = 1'b0;
    logic [3:0]  sel     = 4'hF;
    logic        cap1, cap2, ext, pin1, oe1, pin2, oe2, irq, pin_lvl;
    mode_e       mode;
    logic [7:0]  a, b, v;
    int          n, lows, n_errors = 0, compares = 0;
    int          dv[3] = '{4, 2, 8};

    // 100 MHz system clock
    always #5 sys_clk = ~sys_clk;

    wave_timer dut (
        .sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .capture_pin_1(cap1), .capture_pin_2(cap2), .ext_clk_pin(ext), .halt_mode(halt),
        .compare_output_pin_1(pin1), .compare_output_oe_1(oe1), .compare_output_pin_2(pin2),
        .compare_output_oe_2(oe2), .timer_irq(irq), .mode(mode)
    );

    pin_partner load (
        .sys_clk(sys_clk), .out_pin(pin1), .out_oe(oe1), .capture_pin_1(cap1),
        .capture_pin_2(cap2), .ext_clk_pin(ext), .pin_level(pin_lvl)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Reporting
    task end_of_test;
        $display("Compares %0d, errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // A wait that runs out counts as a mismatch and ends the run
    task tmo;
        check(32'h0, 32'h1);
        end_of_test();
    endtask : tmo

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone classic cycles; the request holds until ack is sampled high
    task wait_ack;
        int k;
        for (k = 0; k < 20; k++) begin
            @(posedge sys_clk);
            if (ack === 1'b1) break;
        end
        if (k == 20) tmo();
    endtask : wait_ack

    task wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= 1'b1; adr <= ad; dat_i <= {24'h0, d};
        wait_ack();
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] ad, output logic [7:0] d);
        @(posedge sys_clk);
        cyc <= 1'b1; stb <= 1'b1; adr <= ad;
        wait_ack();
        d = dat_o[7:0];
        cyc <= 1'b0; stb <= 1'b0;
    endtask : rd

    // Read, mask and compare one register byte
    task rc(input logic [7:0] ad, input logic [7:0] m, input logic [7:0] e);
        rd(ad, v);
        check(v & m, e);
    endtask : rc

    // Cycles until the loaded pin reaches a level; long enough for a full PWM period
    task wait_pin(input logic lv, output int cnt);
        cnt = 0;
        while (pin_lvl !== lv) begin
            if (cnt == 600) tmo();
            cnt++;
            @(posedge sys_clk);
        end
    endtask : wait_pin

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        // Forced output follows the level bit without raising a compare flag
        wr(`OFS_CTRL_TWO, 8'hC0);
        wr(`OFS_CTRL_ONE, 8'h1D);
        repeat (4) @(posedge sys_clk);
        check(pin_lvl, 1'b1);
        check({oe2, pin2}, 2'h3);
        wr(`OFS_CTRL_ONE, 8'h18);
        repeat (4) @(posedge sys_clk);
        check(pin_lvl, 1'b0);
        check(pin2, 1'b0);
        rc(`OFS_STATUS, 8'hC8, 8'h00);
        check(irq, 1'b0);
        // In one pulse mode the force bit is ignored
        wr(`OFS_CTRL_TWO, 8'hA4);
        wr(`OFS_CTRL_ONE, 8'h0B);
        repeat (8) @(posedge sys_clk);
        check(pin_lvl, 1'b0);
        check(mode, MODE_ONE_PULSE);
        // Pulse of 20 ticks: compare holds ticks minus 5
        wr(`OFS_CMP1_HI, 8'h00);
        wr(`OFS_CMP1_LO, 8'd15);
        wr(`OFS_CTRL_ONE, 8'h06);
        fork load.pulse(0); join_none
        wait_pin(1'b1, n);
        wait_pin(1'b0, n);
        check(n >= 36 && n <= 44, 1'b1);
        rc(`OFS_STATUS, 8'hC0, 8'h80);
        rc(`OFS_CAP1_HI, 8'hFF, 8'hFF);
        rc(`OFS_CAP1_LO, 8'hFF, 8'hFD);
        rc(`OFS_STATUS, 8'h80, 8'h00);
        // PWM values set ahead: high at 80, reload at 240
        wr(`OFS_CMP1_LO, 8'h50);
        wr(`OFS_CMP2_HI, 8'h00);
        wr(`OFS_CMP2_LO, 8'hF0);
        // Equal levels: the pin never returns after the match
        wr(`OFS_CTRL_ONE, 8'h07);
        fork load.pulse(0); join_none
        wait_pin(1'b1, n);
        repeat (200) @(posedge sys_clk);
        check(pin_lvl, 1'b1);
        // Both mode bits set run PWM; level1 high, level2 low
        wr(`OFS_CTRL_ONE, 8'h81);
        wr(`OFS_CTRL_TWO, 8'hB6);
        // The write lands at the ack edge; look one edge later
        @(posedge sys_clk);
        check(mode, MODE_PWM);
        wait_pin(1'b0, n);
        wait_pin(1'b1, n);
        check(n, 170);
        fork load.pulse(0); join_none
        wait_pin(1'b0, n);
        check(n, 320);
        rc(`OFS_STATUS, 8'hD8, 8'h80);
        check(irq, 1'b1);
        load.pulse(1);
        rc(`OFS_STATUS, 8'h10, 8'h10);
        // High byte alone stops the period reload, so the pin never falls
        wr(`OFS_CMP2_HI, 8'h00);
        wait_pin(1'b1, n);
        lows = 0;
        repeat (500) begin
            @(posedge sys_clk);
            if (pin_lvl !== 1'b1) lows++;
        end
        check(lows, 0);
        wr(`OFS_CTRL_ONE, 8'h00);
        // Prescaler codes, then external ticks on rising edges
        for (int i = 0; i < 3; i++) begin
            wr(`OFS_CTRL_TWO, {4'h0, 2'(i), 2'b00});
            rd(`OFS_CNT_LO, a);
            // The two reads latch the count exactly 80 cycles apart
            repeat (77) @(posedge sys_clk);
            rd(`OFS_CNT_LO, b);
            check(8'(b - a) >= 80 / dv[i] - 1 && 8'(b - a) <= 80 / dv[i] + 1, 1'b1);
        end
        wr(`OFS_CTRL_TWO, 8'h0D);
        rd(`OFS_CNT_LO, a);
        repeat (10) load.pulse(2);
        rd(`OFS_CNT_LO, b);
        check(8'(b - a), 8'd10);
        // Halt freezes the count; an edge in halt is captured at exit
        wr(`OFS_CTRL_TWO, 8'h06);
        wr(`OFS_CTRL_ONE, 8'h80);
        rd(`OFS_STATUS, v);
        rd(`OFS_CAP2_LO, v);
        rd(`OFS_CAP1_LO, v);
        rc(`OFS_STATUS, 8'h90, 8'h00);
        check(irq, 1'b0);
        @(posedge sys_clk);
        halt <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rd(`OFS_CNT_LO, a);
        load.pulse(1);
        rd(`OFS_CNT_LO, b);
        check(b, a);
        rc(`OFS_STATUS, 8'h10, 8'h00);
        @(posedge sys_clk);
        halt <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rc(`OFS_STATUS, 8'h10, 8'h10);
        check(irq, 1'b1);
        rc(`OFS_CAP2_LO, 8'hFF, a);
        rc(8'hFC, 8'hFF, 8'h00);
        // A write with byte lane 0 off is ignored
        sel <= 4'hE;
        wr(`OFS_CMP1_LO, 8'hAA);
        sel <= 4'hF;
        rc(`OFS_CMP1_LO, 8'hFF, 8'h50);
        // Reset wake from halt restarts from the reset count
        @(posedge sys_clk);
        halt <= 1'b1;
        rstn <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rstn <= 1'b1;
        halt <= 1'b0;
        rc(`OFS_CNT_HI, 8'hFF, 8'hFF);
        end_of_test();
    end
endmodule : tb_timer_one_pulse_pwm_modes
`default_nettype wire
